// >>> relay_pwm_pkg.sv
package relay_pwm_pkg;

    // register offsets on the die-to-die bus
    localparam logic [7:0] SINK_CTRL_OFS     = 8'h30;
    localparam logic [7:0] SINK_STAT_OFS     = 8'h31;
    localparam logic [7:0] SINK_UNLOCK_OFS   = 8'h32;
    localparam logic [7:0] VOLT_STAT_OFS     = 8'h33;
    localparam logic [7:0] IRQ_SRC_OFS       = 8'h34;
    localparam logic [7:0] IRQ_MASK_OFS      = 8'h35;
    localparam logic [7:0] MOD_CTRL_OFS      = 8'h60;
    localparam logic [7:0] PRESCALE_OFS      = 8'h61;
    localparam logic [7:0] SCALE_A_OFS       = 8'h62;
    localparam logic [7:0] SCALE_B_OFS       = 8'h63;
    localparam logic [7:0] CNT0_OFS          = 8'h64;
    localparam logic [7:0] CNT1_OFS          = 8'h65;
    localparam logic [7:0] PER0_OFS          = 8'h66;
    localparam logic [7:0] PER1_OFS          = 8'h67;
    localparam logic [7:0] DTY0_OFS          = 8'h68;
    localparam logic [7:0] DTY1_OFS          = 8'h69;

    // field positions
    localparam int SINK_EN_LO       = 0;
    localparam int SINK_MODEN_LO    = 2;
    localparam int SINK_CHSEL_LO    = 4;
    localparam int SINK_OTIE_BIT    = 7;
    localparam int VOLT_OV_BIT      = 0;
    localparam int VOLT_OVIE_BIT    = 1;
    localparam int IRQ_SINK_BIT     = 0;
    localparam int IRQ_OV_BIT       = 1;
    localparam int MOD_EN_LO        = 0;
    localparam int MOD_POL_LO       = 2;
    localparam int MOD_CLKSEL_LO    = 4;
    localparam int MOD_CAE_LO       = 6;

    // reset values and masks
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [3:0] UNLOCK_KEY      = 4'h5;
    localparam logic [7:0] PRESCALE_MASK   = 8'h77;
    localparam logic [7:0] SINK_CTRL_MASK  = 8'hbf;
    localparam logic [7:0] IRQ_MASK_MASK   = 8'h03;
    localparam logic [7:0] VOLT_WR_MASK    = 8'h02;

    typedef struct packed {
        logic       regOvervolt;
        logic       overTemp;
        logic [1:0] openLoad;
        logic [1:0] currentLimit;
    } analog_flags_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

endpackage

// >>> relay_driver_pwm_control.sv
// Operation
// (RULE1) overvoltage switches both sinks off immediately
// (RULE2) overvoltage clears both sink enable bits
// (RULE3) overvoltage flag follows live condition
// (RULE4) enabled overvoltage raises its interrupt
// (RULE5) reading voltage status clears overvoltage interrupt
// (RULE6) new interrupt only on fresh overvoltage
// (RULE7) host unlocks with 0x05, then re-enables
// (RULE8) open-load bit set below load threshold
// (RULE9) open-load masked while driver is off
// (RULE10) current-limit bit shows limiting driver
// (RULE11) overtemp kills both sinks, latches source
// (RULE12) overtemp interrupt only when mask set
// (RULE13) control write re-enables after overtemp clears
// (RULE14) two channels, own counter, period, duty
// (RULE15) four clock sources per channel choice; each channel here picks from two only (A or SA, B or SB)
// (RULE16) duty spans zero to full output
// (RULE17) period and duty buffered until counter zero
// (RULE18) left or center alignment per channel
// (RULE19) per-channel duty polarity select
// (RULE20) modulator idle outside normal mode
// (RULE21) reserved bits read zero, ignore writes
// (RULE22) eight-bit counters, periods, duties, scales
// (RULE23) sinks obey enables only after 0x5 unlock
// (RULE24) per-sink channel select and modulation gate
// (RULE25) reading sink status clears overtemp interrupt
// (RULE26) sinks disabled outside normal mode
// (RULE27) analog flags synchronised before use
`timescale 1ns/100ps
`default_nettype none
module relay_driver_pwm_control
    import relay_pwm_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic          normalMode,
    input  wire bus_req_s      busReq,
    output logic [7:0]         busRdata,
    input  wire analog_flags_s analogIn,
    output logic [1:0]         sinkDriveOn,
    output logic [1:0]         waveOut,
    output logic               irqOut
);

    // =======================================================
    // flag synchroniser
    analog_flags_s syncA;
    analog_flags_s syncB;
    analog_flags_s syncC;
    analog_flags_s flags;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            flags <= '0;
        end
        else
        begin
            syncA <= analogIn; // RULE27
            syncB <= syncA;
            syncC <= syncB;
            if (syncB == syncC)
            begin
                flags <= syncC; // RULE27
            end
        end
    end

    // =======================================================
    // bus decode
    logic wrSinkCtrl;
    logic rdSinkStat;
    logic rdVoltStat;

    function automatic logic hit(input logic strobe,
                                 input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = strobe && (a == ofs);
    endfunction

    assign wrSinkCtrl = hit(busReq.wr, busReq.addr, SINK_CTRL_OFS);
    assign rdSinkStat = hit(busReq.rd, busReq.addr, SINK_STAT_OFS);
    assign rdVoltStat = hit(busReq.rd, busReq.addr, VOLT_STAT_OFS);

    // =======================================================
    // sink driver control
    logic [7:0] sinkCtrl;
    logic [3:0] unlockField;
    logic       unlocked;
    logic       ovPrev;
    logic       ovIrq;
    logic       ovIrqEn;
    logic       otPrev;
    logic       otIrq;
    logic [7:0] irqMask;
    logic       ovRise;
    logic       otRise;

    assign unlocked = (unlockField == UNLOCK_KEY); // RULE23
    assign ovRise   = flags.regOvervolt && !ovPrev; // RULE6
    assign otRise   = flags.overTemp && !otPrev;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sinkCtrl <= RESET_BYTE;
        end
        else if (flags.regOvervolt)
        begin
            sinkCtrl[SINK_EN_LO +: 2] <= 2'h0; // RULE2
        end
        else if (wrSinkCtrl)
        begin
            sinkCtrl <= busReq.wdata & SINK_CTRL_MASK; // RULE13
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            unlockField <= 4'h0;
        end
        else if (ovRise)
        begin
            unlockField <= 4'h0; // RULE7
        end
        else if (hit(busReq.wr, busReq.addr, SINK_UNLOCK_OFS))
        begin
            unlockField <= busReq.wdata[3:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ovPrev  <= 1'b0;
            otPrev  <= 1'b0;
            ovIrq   <= 1'b0;
            otIrq   <= 1'b0;
            ovIrqEn <= 1'b0;
            irqMask <= RESET_BYTE;
        end
        else
        begin
            ovPrev <= flags.regOvervolt;
            otPrev <= flags.overTemp;
            if (ovRise && ovIrqEn)
            begin
                ovIrq <= 1'b1; // RULE4
            end
            else if (rdVoltStat)
            begin
                ovIrq <= 1'b0; // RULE5
            end
            if (otRise)
            begin
                otIrq <= 1'b1; // RULE11
            end
            else if (rdSinkStat)
            begin
                otIrq <= 1'b0; // RULE25
            end
            if (hit(busReq.wr, busReq.addr, VOLT_STAT_OFS))
            begin
                ovIrqEn <= busReq.wdata[VOLT_OVIE_BIT];
            end
            if (hit(busReq.wr, busReq.addr, IRQ_MASK_OFS))
            begin
                irqMask <= busReq.wdata & IRQ_MASK_MASK;
            end
        end
    end

    assign irqOut = (otIrq && irqMask[IRQ_SINK_BIT]) // RULE12
                    || ovIrq;

    // =======================================================
    // modulator registers
    logic [7:0] modCtrl;
    logic [7:0] prescaleSel;
    logic [7:0] scaleA;
    logic [7:0] scaleB;
    logic [WIDTH-1:0] perBuf [2];
    logic [WIDTH-1:0] dtyBuf [2];
    logic [WIDTH-1:0] perAct [2];
    logic [WIDTH-1:0] dtyAct [2];
    logic [WIDTH-1:0] cnt    [2];
    logic [1:0]       cntClr;
    logic [1:0]       downDir;
    logic [1:0]       wave;
    logic [1:0]       chanEn;

    assign chanEn = modCtrl[MOD_EN_LO +: 2] & {2{normalMode}}; // RULE20

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            modCtrl     <= RESET_BYTE;
            prescaleSel <= RESET_BYTE;
            scaleA      <= RESET_BYTE;
            scaleB      <= RESET_BYTE;
            perBuf[0]   <= '0;
            perBuf[1]   <= '0;
            dtyBuf[0]   <= '0;
            dtyBuf[1]   <= '0;
        end
        else if (busReq.wr)
        begin
            case (busReq.addr)
                MOD_CTRL_OFS: modCtrl     <= busReq.wdata;
                PRESCALE_OFS: prescaleSel <= busReq.wdata & PRESCALE_MASK; // RULE21
                SCALE_A_OFS:  scaleA      <= busReq.wdata; // RULE22
                SCALE_B_OFS:  scaleB      <= busReq.wdata;
                PER0_OFS:     perBuf[0]   <= busReq.wdata[WIDTH-1:0]; // RULE17
                PER1_OFS:     perBuf[1]   <= busReq.wdata[WIDTH-1:0];
                DTY0_OFS:     dtyBuf[0]   <= busReq.wdata[WIDTH-1:0];
                DTY1_OFS:     dtyBuf[1]   <= busReq.wdata[WIDTH-1:0];
                default:      modCtrl     <= modCtrl;
            endcase
        end
    end

    assign cntClr[0] = hit(busReq.wr, busReq.addr, CNT0_OFS);
    assign cntClr[1] = hit(busReq.wr, busReq.addr, CNT1_OFS);

    // =======================================================
    // clock sources A, B, SA, SB
    logic [6:0] prescaler;
    logic [1:0] preTick;
    logic [7:0] scaleCnt [2];
    logic [1:0] scaleTick;
    logic [1:0] chanTick;

    function automatic logic preSel(input logic [6:0] p,
                                    input logic [2:0] s);
        logic [7:0] m;
        m = (8'h01 << s) - 8'h01;
        preSel = ((p & m[6:0]) == m[6:0]);
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || chanEn == 2'b00)
        begin
            prescaler <= 7'h00;
        end
        else
        begin
            prescaler <= prescaler + 7'h01;
        end
    end

    assign preTick[0] = (chanEn != 2'b00)
                        && preSel(prescaler, prescaleSel[2:0]);
    assign preTick[1] = (chanEn != 2'b00)
                        && preSel(prescaler, prescaleSel[6:4]);

    // scaled clocks divide by 2*scale, scale 0 meaning 256
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_scale
            logic [7:0] scaleVal;
            logic [8:0] lim;
            assign scaleVal = (g == 0) ? scaleA : scaleB;
            assign lim = {scaleVal == 8'h00, scaleVal};
            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                begin
                    scaleCnt[g] <= 8'h00;
                end
                else if (preTick[g])
                begin
                    if ({1'b0, scaleCnt[g]} + 9'h001 >= lim)
                    begin
                        scaleCnt[g] <= 8'h00;
                    end
                    else
                    begin
                        scaleCnt[g] <= scaleCnt[g] + 8'h01;
                    end
                end
            end
            logic half;
            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                begin
                    half <= 1'b0;
                end
                else if (preTick[g]
                         && {1'b0, scaleCnt[g]} + 9'h001 >= lim)
                begin
                    half <= !half;
                end
            end
            assign scaleTick[g] = preTick[g] && half
                && ({1'b0, scaleCnt[g]} + 9'h001 >= lim);
            assign chanTick[g] = modCtrl[MOD_CLKSEL_LO + g]
                                 ? scaleTick[g] : preTick[g]; // RULE15

            // ===============================================
            // channel counter and waveform
            logic atEnd;
            logic center;
            logic pol;
            logic active;
            assign center = modCtrl[MOD_CAE_LO + g];
            assign pol    = modCtrl[MOD_POL_LO + g];
            // center mode walks 0..per-1 up, then per-1..0 down
            assign atEnd  = center
                ? (downDir[g] && cnt[g] == '0) || perAct[g] == '0
                : (cnt[g] + 1'b1 >= perAct[g]);

            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                begin
                    cnt[g]     <= '0;
                    downDir[g] <= 1'b0;
                    perAct[g]  <= '0;
                    dtyAct[g]  <= '0;
                end
                else if (!chanEn[g] || cntClr[g])
                begin
                    cnt[g]     <= '0;
                    downDir[g] <= 1'b0;
                    perAct[g]  <= perBuf[g]; // RULE17
                    dtyAct[g]  <= dtyBuf[g];
                end
                else if (chanTick[g])
                begin
                    if (atEnd)
                    begin
                        cnt[g]     <= '0; // RULE14
                        downDir[g] <= 1'b0;
                        perAct[g]  <= perBuf[g]; // RULE17
                        dtyAct[g]  <= dtyBuf[g];
                    end
                    else if (center && !downDir[g]
                             && cnt[g] + 1'b1 >= perAct[g])
                    begin
                        downDir[g] <= 1'b1; // RULE18
                    end
                    else if (downDir[g])
                    begin
                        cnt[g] <= cnt[g] - 1'b1;
                    end
                    else
                    begin
                        cnt[g] <= cnt[g] + 1'b1;
                    end
                end
            end

            // duty 0 gives idle level, duty >= period full level
            assign active = (cnt[g] < dtyAct[g]); // RULE16
            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                begin
                    wave[g] <= 1'b0;
                end
                else
                begin
                    wave[g] <= chanEn[g]
                        && (pol ? active : !active); // RULE19
                end
            end
        end
    endgenerate

    assign waveOut = wave; // RULE22

    // =======================================================
    // sink drive outputs
    logic [1:0] next_sinkDrive;
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            next_sinkDrive[i] = sinkCtrl[SINK_EN_LO + i] && unlocked // RULE23
                && (!sinkCtrl[SINK_MODEN_LO + i]
                    || wave[sinkCtrl[SINK_CHSEL_LO + i]]); // RULE24
        end
        if (flags.regOvervolt || flags.overTemp || !normalMode)
        begin
            next_sinkDrive = 2'b00; // RULE1 RULE11 RULE26
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sinkDriveOn <= 2'b00;
        end
        else
        begin
            sinkDriveOn <= next_sinkDrive;
        end
    end

    // =======================================================
    // read mux
    logic [7:0] sinkStat;
    assign sinkStat = {flags.overTemp, 3'h0,
                       flags.currentLimit, // RULE10
                       flags.openLoad & sinkDriveOn}; // RULE8 RULE9

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            busRdata <= RESET_BYTE;
        end
        else
        begin
            case (busReq.addr)
                SINK_CTRL_OFS:   busRdata <= sinkCtrl;
                SINK_STAT_OFS:   busRdata <= sinkStat;
                SINK_UNLOCK_OFS: busRdata <= {4'h0, unlockField};
                VOLT_STAT_OFS:   busRdata <= {6'h0, ovIrqEn,
                                              flags.regOvervolt}; // RULE3
                IRQ_SRC_OFS:     busRdata <= {6'h0, ovIrq, otIrq};
                IRQ_MASK_OFS:    busRdata <= irqMask;
                MOD_CTRL_OFS:    busRdata <= modCtrl;
                PRESCALE_OFS:    busRdata <= prescaleSel;
                SCALE_A_OFS:     busRdata <= scaleA;
                SCALE_B_OFS:     busRdata <= scaleB;
                CNT0_OFS:        busRdata <= cnt[0];
                CNT1_OFS:        busRdata <= cnt[1];
                PER0_OFS:        busRdata <= perBuf[0];
                PER1_OFS:        busRdata <= perBuf[1];
                DTY0_OFS:        busRdata <= dtyBuf[0];
                DTY1_OFS:        busRdata <= dtyBuf[1];
                default:         busRdata <= 8'h00;
            endcase
        end
    end

    // =======================================================
    // checks
    AST_OV_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        flags.regOvervolt |=> sinkDriveOn == 2'b00) // RULE1
        else $error("drivers on during overvoltage");
    AST_OV_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        flags.regOvervolt |=> sinkCtrl[1:0] == 2'b00) // RULE2
        else $error("enable bits kept in overvoltage");
    AST_OV_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ovRise && ovIrqEn |=> ovIrq) // RULE4
        else $error("overvoltage interrupt missing");
    AST_OV_RDCLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rdVoltStat && !(ovRise && ovIrqEn) |=> !ovIrq) // RULE5
        else $error("overvoltage interrupt not cleared");
    AST_OV_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !ovIrq && $past(flags.regOvervolt) && flags.regOvervolt
        |=> !ovIrq) // RULE6
        else $error("persisting overvoltage re-raised");
    AST_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !unlocked |=> sinkDriveOn == 2'b00) // RULE23
        else $error("drivers on while locked");
    AST_OT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        flags.overTemp |=> sinkDriveOn == 2'b00) // RULE11
        else $error("drivers on during overtemp");
    AST_OT_RDCLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rdSinkStat && !otRise |=> !otIrq) // RULE25
        else $error("overtemp interrupt not cleared");
    AST_MODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !normalMode |=> waveOut == 2'b00 && sinkDriveOn == 2'b00) // RULE20
        else $error("active outside normal mode");

endmodule
`default_nettype wire

// >>> analog_sink_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_sink_model
    import relay_pwm_pkg::*;
(
    input  wire logic [1:0] driveOn,
    input  wire logic       ovCmd,
    input  wire logic       otCmd,
    input  wire logic [1:0] loadOpen,
    input  wire logic [1:0] overCurrent,
    output var analog_flags_s analogIn
);
    // ========================================
    // analog flag levels
    assign analogIn.regOvervolt = ovCmd;
    assign analogIn.overTemp = otCmd;
    // an off sink carries no current, so it reads as open
    assign analogIn.openLoad = loadOpen | ~driveOn;
    assign analogIn.currentLimit = overCurrent & driveOn;
endmodule
`default_nettype wire

// >>> tb_relay_driver_pwm_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_relay_driver_pwm_control import relay_pwm_pkg::*;;
    logic          ref_clk;
    logic          rst_b;
    logic          normalMode;
    bus_req_s      busReq;
    logic [7:0]    busRdata;
    analog_flags_s analogIn;
    logic [1:0]    sinkDriveOn;
    logic [1:0]    waveOut;
    logic          irqOut;
    logic          ovCmd;
    logic          otCmd;
    logic [1:0]    loadOpen;
    logic [1:0]    overCurrent;
    logic [7:0]    rdata;
    int            errCount;
    int            checks;
    int            ones [4];
    int            e0;
    int            e1;

    relay_driver_pwm_control relay_driver_pwm_control_i (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .normalMode (normalMode),
        .busReq     (busReq),
        .busRdata   (busRdata),
        .analogIn   (analogIn),
        .sinkDriveOn(sinkDriveOn),
        .waveOut    (waveOut),
        .irqOut     (irqOut)
    );

    analog_sink_model analog_sink_model_i (
        .driveOn    (sinkDriveOn),
        .ovCmd      (ovCmd),
        .otCmd      (otCmd),
        .loadOpen   (loadOpen),
        .overCurrent(overCurrent),
        .analogIn   (analogIn)
    );

    // ========================================
    // clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        #200000;
        errCount++;
        final_report();
    end

    // ========================================
    // bus and check tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq.wr <= 1'b1;
        busReq.addr <= a;
        busReq.wdata <= d;
        @(posedge ref_clk);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        busReq.rd <= 1'b1;
        busReq.addr <= a;
        @(posedge ref_clk);
        busReq.rd <= 1'b0;
        #1;
        rdata = busRdata;
    endtask

    task automatic cr(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic drv(input logic [1:0] exp);
        check({14'h0000, sinkDriveOn}, {14'h0000, exp});
    endtask

    task automatic irq(input logic exp);
        check({15'h0000, irqOut}, {15'h0000, exp});
    endtask

    task automatic measure();
        ones = '{default: 0};
        repeat (256)
        begin
            @(posedge ref_clk);
            #1;
            for (int k = 0; k < 2; k++)
            begin
                ones[k] += (waveOut[k] === 1'b1);
                ones[k + 2] += (sinkDriveOn[k] === 1'b1);
            end
        end
    endtask

    task automatic final_report();
        if (errCount == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ========================================
    // test sequence
    initial
    begin
        rst_b = 1'b0;
        normalMode = 1'b1;
        busReq = '0;
        {ovCmd, otCmd, loadOpen, overCurrent} = '0;
        errCount = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int a = 8'h30; a <= 8'h35; a++)
            cr(a[7:0], RESET_BYTE);
        for (int a = 8'h60; a <= 8'h69; a++)
            cr(a[7:0], RESET_BYTE);
        cr(8'h7f, 8'h00);
        wr(PRESCALE_OFS, 8'hff);
        cr(PRESCALE_OFS, 8'h77);
        wr(SINK_UNLOCK_OFS, 8'hf3);
        wr(SINK_CTRL_OFS, 8'h01);
        wt(4);
        drv(2'b00);
        wr(SINK_UNLOCK_OFS, 8'h05);
        wr(SINK_CTRL_OFS, 8'h03);
        wt(4);
        drv(2'b11);
        @(posedge ref_clk) {loadOpen, overCurrent} <= 4'b0110;
        wt(10);
        cr(SINK_STAT_OFS, 8'h09);
        @(posedge ref_clk) {loadOpen, overCurrent} <= 4'b1100;
        wr(VOLT_STAT_OFS, 8'h02);
        @(posedge ref_clk) ovCmd <= 1'b1;
        wt(10);
        drv(2'b00);
        irq(1'b1);
        cr(SINK_CTRL_OFS, 8'h00);
        cr(VOLT_STAT_OFS, 8'h03);
        wt(2);
        irq(1'b0);
        cr(SINK_STAT_OFS, 8'h00);
        wt(10);
        irq(1'b0);
        @(posedge ref_clk) ovCmd <= 1'b0;
        wt(10);
        cr(VOLT_STAT_OFS, 8'h02);
        wr(SINK_CTRL_OFS, 8'h01);
        wt(4);
        drv(2'b00);
        wr(SINK_UNLOCK_OFS, 8'h05);
        wr(SINK_CTRL_OFS, 8'h01);
        wt(4);
        drv(2'b01);
        @(posedge ref_clk) ovCmd <= 1'b1;
        wt(10);
        irq(1'b1);
        cr(VOLT_STAT_OFS, 8'h03);
        @(posedge ref_clk) ovCmd <= 1'b0;
        wt(10);
        wr(SINK_UNLOCK_OFS, 8'h05);
        wr(SINK_CTRL_OFS, 8'h03);
        wr(IRQ_MASK_OFS, 8'h00);
        @(posedge ref_clk) otCmd <= 1'b1;
        wt(10);
        drv(2'b00);
        irq(1'b0);
        rd(IRQ_SRC_OFS);
        check({8'h00, rdata & 8'h01}, 16'h0001);
        wr(IRQ_MASK_OFS, 8'h01);
        wt(2);
        irq(1'b1);
        cr(SINK_STAT_OFS, 8'h80);
        wt(2);
        irq(1'b0);
        @(posedge ref_clk) {otCmd, loadOpen} <= 3'b000;
        wt(10);
        wr(SINK_CTRL_OFS, 8'h03);
        wt(4);
        drv(2'b11);
        // modulator: modes, polarity, clocks and full duty range
        wr(SCALE_A_OFS, 8'h01);
        wr(SCALE_B_OFS, 8'h01);
        wr(SINK_CTRL_OFS, 8'h1f);
        for (int m = 0; m < 8; m++)
        begin
            for (int d = 0; d <= 4; d++)
            begin
                wr(MOD_CTRL_OFS, 8'h00);
                wr(PRESCALE_OFS, m[1] ? 8'h00 : 8'h11);
                wr(PER0_OFS, 8'h04);
                wr(PER1_OFS, 8'h04);
                wr(DTY0_OFS, 8'(d));
                wr(DTY1_OFS, 8'(4 - d));
                wr(MOD_CTRL_OFS, {{2{m[2]}}, {2{m[1]}}, {2{m[0]}}, 2'b11});
                wt(40);
                measure();
                e0 = m[0] ? 64 * d : 64 * (4 - d);
                e1 = m[0] ? 64 * (4 - d) : 64 * d;
                check(16'(ones[0]), 16'(e0));
                check(16'(ones[1]), 16'(e1));
                check(16'(ones[2]), 16'(e1));
                check(16'(ones[3]), 16'(e0));
            end
        end
        @(posedge ref_clk) normalMode <= 1'b0;
        wt(10);
        measure();
        check(16'(ones[0]), 16'h0000);
        check(16'(ones[3]), 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
